// ### verilog/t1lb_loopback_sync.sv
// loopback mux, loop code generator, code detection, framing check and misc status
// How it works
// [RL1] payload is the 192 bits after the framing bit of each 193-bit frame
// [RL2] payload loopback returns only t1 channels; framer adds fresh framing and crc
// [RL3] payload loopback puts the framer receive stream on the serial data output
// [RL4] system transmit, framer receive and framer transmit input are wired externally
// [RL5] control bits 00 pass, 01 payload loop, 10 send 00001, 11 send 001
// [RL6] loop codes are generated on the serial data output in all 24 channels
// [RL7] disable-detected bit 4 sets after five frames of repeating 001
// [RL8] enable-detected bit 3 sets after five frames of repeating 00001
// [RL9] both detectors tolerate three errors per thousand bits
// [RL10] software waits five seconds of detect before switching line loopback
// [RL11] own sf and esf alignment from the dual-rail line and 8 khz timing
// [RL12] count-valid bit 2 needs two clean superframes and framer sync not lost
// [RL13] framing error count is frozen while count-valid is low
// [RL14] sf checks ft and fs (not sixth fs) when framing select set, else ft
// [RL15] count-valid drops on two errors in four framing bits or framer sync loss
// [RL16] status bit 1 toggles once per second
// [RL17] status bit 0 is high while a valid bit-oriented message is held
// [RL18] status bits 7 to 5 read as zero
`include "t1lb_cfg.svh"
`default_nettype none

module t1lb_loopback_sync
	import t1lb_pkg::*;
#(
	parameter logic [12:0] FRAMES_PER_SEC = `T1LB_FRAMES_PER_SEC
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 stbus_frame_pulse,
	input  wire logic                 stbus_bit_tick,
	input  wire logic                 tx_stream_in,
	input  wire logic                 rx_stream_in,
	input  wire logic                 control_stream_in,
	input  wire logic                 framer_status_in,
	input  wire logic                 line_bit_tick,
	input  wire logic                 rx_rail_a_n,
	input  wire logic                 rx_rail_b_n,
	input  wire logic                 extracted_8k_in,
	input  wire logic                 esf_mode_in,
	input  wire logic                 bom_present_in,
	input  wire logic [14:0]          bom_word_in,
	output var  logic                 serial_data_out,
	output var  logic                 status_stream_out,
	output var  t1lb_misc_status_type misc_status_word,
	output var  logic [3:0]           frame_error_count
);

	// ************************************************************
	// stream side state
	// ************************************************************
	logic [7:0]           pos_reg,      pos_next;
	logic                 loop_hi_reg,  loop_hi_next;
	t1lb_loop_mode_type   loop_mode_reg, loop_mode_next;
	logic                 framing_bits_select_reg,     framing_bits_select_next;
	logic                 sync_lost_reg, sync_lost_next;
	logic [2:0]           gen_phase_reg, gen_phase_next;
	logic                 sdo_reg,      sdo_next;
	logic                 sto_reg,      sto_next;
	logic [12:0]          sec_cnt_reg,  sec_cnt_next;
	logic                 tmr_reg,      tmr_next;
	logic [7:0]           cur_pos;
	logic [4:0]           cur_ch;
	logic [2:0]           cur_b;
	logic                 t1_ch;
	logic [2:0]           code_last;
	logic                 code_bit;

	// ************************************************************
	// line side state
	// ************************************************************
	logic                 e8_prev_reg,  e8_prev_next;
	logic                 e8_pend_reg,  e8_pend_next;
	logic [7:0]           lpos_reg,     lpos_next;
	logic [4:0]           fcnt_reg,     fcnt_next;
	t1lb_sync_state_type  state_reg,    state_next;
	logic [1:0]           clean_reg,    clean_next;
	logic                 sf_err_reg,   sf_err_next;
	logic [3:0]           win_reg,      win_next;
	logic                 valid_reg,    valid_next;
	logic [3:0]           fe_cnt_reg,   fe_cnt_next;
	t1lb_misc_status_type misc_reg,     misc_next;
	logic                 line_bit;
	logic [7:0]           cur_lpos;
	logic                 frame_bit_tick;
	logic                 payload_tick;
	logic [4:0]           sf_last;
	logic                 exp_bit;
	logic                 term_bit;
	logic                 chk_bit;
	logic                 f_err;
	logic                 term_err;
	logic                 en_det;
	logic                 dis_det;

	localparam logic [23:0] SF_PAT  = `T1LB_SF_PATTERN;
	localparam logic [23:0] SF_FT   = `T1LB_SF_FT_MASK;
	localparam logic [23:0] SF_FS   = `T1LB_SF_FS_MASK;
	localparam logic [23:0] ESF_PAT = `T1LB_ESF_PATTERN;
	localparam logic [23:0] ESF_MSK = `T1LB_ESF_MASK;

	// 24 of the 32 stream channels carry t1 channels
	function automatic logic is_t1_channel(input logic [4:0] ch);
		return ch[1:0] != 2'h0;
	endfunction

	// ************************************************************
	// stream position, control capture, output mux, timer
	// ************************************************************
	always_comb begin
		cur_pos   = stbus_frame_pulse ? 8'h00 : pos_reg + 8'h01;
		cur_ch    = cur_pos[7:3];
		cur_b     = 3'h7 - cur_pos[2:0];
		t1_ch     = is_t1_channel(cur_ch);
		code_last = ((loop_mode_reg == T1LB_SEND_DISABLE) ? `T1LB_DISABLE_PERIOD
			: `T1LB_ENABLE_PERIOD) - 3'h1;
		code_bit  = (gen_phase_reg == code_last); // [RL5]
		pos_next       = pos_reg;
		loop_hi_next   = loop_hi_reg;
		loop_mode_next = loop_mode_reg;
		framing_bits_select_next      = framing_bits_select_reg;
		sync_lost_next = sync_lost_reg;
		gen_phase_next = gen_phase_reg;
		sdo_next       = sdo_reg;
		sto_next       = sto_reg;
		sec_cnt_next   = sec_cnt_reg;
		tmr_next       = tmr_reg;
		if (stbus_bit_tick) begin
			pos_next = cur_pos;
			if (cur_ch == `T1LB_CH_LOOP && cur_b == `T1LB_LOOP_HI_BIT) begin
				loop_hi_next = control_stream_in;
			end
			if (cur_ch == `T1LB_CH_LOOP && cur_b == `T1LB_LOOP_LO_BIT) begin
				loop_mode_next = t1lb_loop_mode_type'({loop_hi_reg, control_stream_in}); // [RL5]
			end
			if (cur_ch == `T1LB_CH_CTRL && cur_b == `T1LB_FRAMING_BITS_SELECT_BIT) begin
				framing_bits_select_next = control_stream_in;
			end
			if (cur_ch == `T1LB_CH_LOOP && cur_b == `T1LB_SYNC_LOST_BIT) begin
				sync_lost_next = framer_status_in;
			end
			// framing bits are not in the stream, the framer inserts its own
			case (loop_mode_reg)
				T1LB_PASS: begin
					sdo_next = tx_stream_in; // [RL5]
				end
				T1LB_PAYLOAD: begin
					sdo_next = t1_ch ? rx_stream_in : tx_stream_in; // [RL2] [RL3] [RL4]
				end
				T1LB_SEND_ENABLE, T1LB_SEND_DISABLE: begin
					sdo_next = t1_ch ? code_bit : tx_stream_in; // [RL6]
				end
				default: begin
					sdo_next = tx_stream_in;
				end
			endcase
			if (t1_ch && (loop_mode_reg == T1LB_SEND_ENABLE
				|| loop_mode_reg == T1LB_SEND_DISABLE)) begin
				gen_phase_next = (gen_phase_reg >= code_last) ? 3'h0 : gen_phase_reg + 3'h1;
			end
			sto_next = (cur_ch == `T1LB_CH_MISC) ? misc_reg[cur_b] : framer_status_in;
			if (stbus_frame_pulse) begin
				if (sec_cnt_reg >= FRAMES_PER_SEC - 13'h1) begin
					sec_cnt_next = 13'h0;
					tmr_next     = ~tmr_reg; // [RL16]
				end else begin
					sec_cnt_next = sec_cnt_reg + 13'h1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pos_reg       <= 8'hff;
			loop_hi_reg   <= 1'b0;
			loop_mode_reg <= T1LB_PASS;
			framing_bits_select_reg      <= 1'b0;
			sync_lost_reg <= 1'b1;
			gen_phase_reg <= 3'h0;
			sdo_reg       <= 1'b0;
			sto_reg       <= 1'b0;
			sec_cnt_reg   <= 13'h0;
			tmr_reg       <= 1'b0;
		end else begin
			pos_reg       <= pos_next;
			loop_hi_reg   <= loop_hi_next;
			loop_mode_reg <= loop_mode_next;
			framing_bits_select_reg      <= framing_bits_select_next;
			sync_lost_reg <= sync_lost_next;
			gen_phase_reg <= gen_phase_next;
			sdo_reg       <= sdo_next;
			sto_reg       <= sto_next;
			sec_cnt_reg   <= sec_cnt_next;
			tmr_reg       <= tmr_next;
		end
	end

	// ************************************************************
	// line framing and alignment
	// ************************************************************
	always_comb begin
		line_bit       = ~rx_rail_a_n | ~rx_rail_b_n;
		cur_lpos       = (e8_pend_reg || lpos_reg >= `T1LB_FRAME_BITS - 8'h01) ? 8'h00
			: lpos_reg + 8'h01; // [RL11]
		frame_bit_tick = line_bit_tick && (cur_lpos == 8'h00);
		payload_tick   = line_bit_tick && (cur_lpos != 8'h00); // [RL1]
		sf_last        = esf_mode_in ? `T1LB_ESF_LAST : `T1LB_SF_LAST;
		exp_bit        = esf_mode_in ? ESF_PAT[fcnt_reg] : SF_PAT[fcnt_reg];
		term_bit       = esf_mode_in ? ESF_MSK[fcnt_reg] : SF_FT[fcnt_reg];
		chk_bit        = term_bit || (!esf_mode_in && framing_bits_select_reg && SF_FS[fcnt_reg]); // [RL14]
		f_err          = chk_bit && (line_bit != exp_bit);
		term_err       = term_bit && (line_bit != exp_bit);
		e8_prev_next = extracted_8k_in;
		e8_pend_next = e8_pend_reg;
		lpos_next    = lpos_reg;
		fcnt_next    = fcnt_reg;
		state_next   = state_reg;
		clean_next   = clean_reg;
		sf_err_next  = sf_err_reg;
		win_next     = win_reg;
		fe_cnt_next  = fe_cnt_reg;
		if (line_bit_tick) begin
			lpos_next    = cur_lpos;
			e8_pend_next = 1'b0;
		end
		if (extracted_8k_in && !e8_prev_reg) begin
			e8_pend_next = 1'b1;
		end
		if (frame_bit_tick) begin
			// hunting slips one frame on each mismatch to try the next phase; sf hunting
			// also uses fs bits, ft alone repeats every four frames and could lock off phase
			if (state_reg == T1LB_HUNT && (f_err || (!esf_mode_in && SF_FS[fcnt_reg]
				&& line_bit != exp_bit))) begin
				fcnt_next   = fcnt_reg;
				clean_next  = 2'h0;
				sf_err_next = 1'b1;
			end else if (fcnt_reg >= sf_last) begin
				fcnt_next   = 5'h00;
				sf_err_next = 1'b0;
				// once qualified, only the two-in-four rule or framer sync loss clears valid
				clean_next  = (clean_reg == 2'h2) ? 2'h2
					: ((sf_err_reg || f_err) ? 2'h0 : clean_reg + 2'h1); // [RL12] [RL15]
			end else begin
				fcnt_next   = fcnt_reg + 5'h01;
				sf_err_next = sf_err_reg || f_err;
			end
			case (state_reg)
				T1LB_HUNT: begin
					if (clean_next != 2'h0) begin
						state_next = T1LB_SYNC;
						win_next   = 4'h0;
					end
				end
				T1LB_SYNC: begin
					if (term_bit) begin
						win_next = {win_reg[2:0], term_err};
					end
					if ((2'(win_next[0]) + 2'(win_next[1]) + 2'(win_next[2])
						+ 2'(win_next[3])) >= 2'h2) begin
						state_next = T1LB_HUNT; // [RL15]
						clean_next = 2'h0;
						win_next   = 4'h0;
					end
				end
				default: begin
					state_next = T1LB_HUNT;
				end
			endcase
			if (valid_reg && f_err) begin
				fe_cnt_next = fe_cnt_reg + 4'h1; // [RL13]
			end
		end
		valid_next = (state_reg == T1LB_SYNC) && (clean_reg == 2'h2)
			&& !sync_lost_reg; // [RL12] [RL15]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			e8_prev_reg <= 1'b0;
			e8_pend_reg <= 1'b0;
			lpos_reg    <= 8'h00;
			fcnt_reg    <= 5'h00;
			state_reg   <= T1LB_HUNT;
			clean_reg   <= 2'h0;
			sf_err_reg  <= 1'b0;
			win_reg     <= 4'h0;
			valid_reg   <= 1'b0;
			fe_cnt_reg  <= 4'h0;
		end else begin
			e8_prev_reg <= e8_prev_next;
			e8_pend_reg <= e8_pend_next;
			lpos_reg    <= lpos_next;
			fcnt_reg    <= fcnt_next;
			state_reg   <= state_next;
			clean_reg   <= clean_next;
			sf_err_reg  <= sf_err_next;
			win_reg     <= win_next;
			valid_reg   <= valid_next;
			fe_cnt_reg  <= fe_cnt_next;
		end
	end

	// ************************************************************
	// loop code detectors on the payload bits
	// ************************************************************
	t1lb_code_detect #(
		.PERIOD      (5),
		.ONES_MIN    (30),
		.ONES_MAX    (47),
		.MISS_MAX    (8),
		.HOLD_FRAMES (5)
	) u_enable_detect (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.bit_tick    (payload_tick),
		.bit_in      (line_bit),
		.frame_start (frame_bit_tick),
		.detected    (en_det)
	);

	t1lb_code_detect #(
		.PERIOD      (3),
		.ONES_MIN    (55),
		.ONES_MAX    (73),
		.MISS_MAX    (8),
		.HOLD_FRAMES (5)
	) u_disable_detect (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.bit_tick    (payload_tick),
		.bit_in      (line_bit),
		.frame_start (frame_bit_tick),
		.detected    (dis_det)
	);

	// ************************************************************
	// miscellaneous status word
	// ************************************************************
	always_comb begin
		misc_next                       = misc_reg;
		misc_next.unused                = 3'h0; // [RL18]
		misc_next.loop_disable_detected = dis_det; // [RL7]
		misc_next.loop_enable_detected  = en_det; // [RL8]
		misc_next.frame_count_valid     = valid_reg;
		misc_next.two_second_toggle     = tmr_reg;
		misc_next.bitmsg_valid          = bom_present_in
			&& ((bom_word_in & `T1LB_BOM_MASK) == `T1LB_BOM_VALUE); // [RL17]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			misc_reg <= '0;
		end else begin
			misc_reg <= misc_next;
		end
	end

	assign serial_data_out   = sdo_reg;
	assign status_stream_out = sto_reg;
	assign misc_status_word  = misc_reg;
	assign frame_error_count = fe_cnt_reg;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_pass_through: assert property ( // [RL5]
		stbus_bit_tick && loop_mode_reg == T1LB_PASS |=> serial_data_out == $past(tx_stream_in))
		else $error("pass mode did not forward transmit data");
	a_payload_loop: assert property ( // [RL3]
		stbus_bit_tick && loop_mode_reg == T1LB_PAYLOAD && t1_ch
		|=> serial_data_out == $past(rx_stream_in))
		else $error("payload loop did not return receive data");
	a_payload_only: assert property ( // [RL2]
		stbus_bit_tick && loop_mode_reg == T1LB_PAYLOAD && !t1_ch
		|=> serial_data_out == $past(tx_stream_in))
		else $error("non-payload channel was looped back");
	a_code_zeros: assert property ( // [RL6]
		stbus_bit_tick && loop_mode_reg == T1LB_SEND_ENABLE && t1_ch && gen_phase_reg != 3'h4
		|=> !serial_data_out)
		else $error("enable code carries a one off its fifth bit");
	a_unused_zero: assert property ( // [RL18]
		misc_status_word.unused == 3'h0)
		else $error("unused status bits not zero");
	a_valid_rise: assert property ( // [RL12]
		$rose(valid_reg) |-> $past(clean_reg) == 2'h2 && !$past(sync_lost_reg))
		else $error("count valid set without two clean superframes");
	a_count_frozen: assert property ( // [RL13]
		!valid_reg |=> $stable(fe_cnt_reg))
		else $error("framing error count moved while not valid");
	a_sync_loss: assert property ( // [RL15]
		sync_lost_reg |=> !valid_reg ##1 !misc_status_word.frame_count_valid)
		else $error("count valid kept while framer sync lost");
	a_timer_wrap: assert property ( // [RL16]
		$changed(tmr_reg) |-> sec_cnt_reg == 13'h0 && $past(stbus_frame_pulse))
		else $error("timer toggled off the one second boundary");
	a_bom_form: assert property ( // [RL17]
		misc_status_word.bitmsg_valid |-> $past(bom_word_in[0]) == 1'b0)
		else $error("message valid with wrong final bit");

endmodule // t1lb_loopback_sync

`default_nettype wire

// ### inc/t1lb_cfg.svh
// constants of the t1 loopback and synchronisation block
`ifndef T1LB_CFG_SVH
`define T1LB_CFG_SVH

// stream channel and bit positions
`define T1LB_CH_MISC        5'h07
`define T1LB_CH_CTRL        5'h0b
`define T1LB_CH_LOOP        5'h0f
`define T1LB_FRAMING_BITS_SELECT_BIT       3'h3
`define T1LB_SYNC_LOST_BIT  3'h0
`define T1LB_LOOP_HI_BIT    3'h1
`define T1LB_LOOP_LO_BIT    3'h0

// t1 frame layout
`define T1LB_FRAME_BITS     8'hc1
`define T1LB_PAYLOAD_BITS   8'hc0
`define T1LB_SF_LAST        5'h0b
`define T1LB_ESF_LAST       5'h17

// framing patterns, bit i belongs to frame i+1
`define T1LB_SF_PATTERN     24'h00_03b1
`define T1LB_SF_FT_MASK     24'h00_0555
`define T1LB_SF_FS_MASK     24'h00_02aa
`define T1LB_ESF_PATTERN    24'h88_0800
`define T1LB_ESF_MASK       24'h88_8888

// loop code periods and timer
`define T1LB_ENABLE_PERIOD  3'h5
`define T1LB_DISABLE_PERIOD 3'h3
`define T1LB_FRAMES_PER_SEC 13'h1f40

// bit-oriented message form 11111110xxxxxx0
`define T1LB_BOM_MASK       15'h7f81
`define T1LB_BOM_VALUE      15'h7f00

`endif

// ### inc/t1lb_pkg.sv
// types shared by the t1 loopback and synchronisation block
`default_nettype none

package t1lb_pkg;

	// encoding order follows control bits 1..0
	typedef enum logic [1:0] {
		T1LB_PASS,
		T1LB_PAYLOAD,
		T1LB_SEND_ENABLE,
		T1LB_SEND_DISABLE
	} t1lb_loop_mode_type;

	typedef enum logic {
		T1LB_HUNT,
		T1LB_SYNC
	} t1lb_sync_state_type;

	typedef struct packed {
		logic [2:0] unused;
		logic       loop_disable_detected;
		logic       loop_enable_detected;
		logic       frame_count_valid;
		logic       two_second_toggle;
		logic       bitmsg_valid;
	} t1lb_misc_status_type;

endpackage

`default_nettype wire

// ### verilog/t1lb_code_detect.sv
// detector for one repeating loop code in the received payload
`default_nettype none

module t1lb_code_detect
	import t1lb_pkg::*;
#(
	parameter int PERIOD      = 5,
	parameter int ONES_MIN    = 30,
	parameter int ONES_MAX    = 47,
	parameter int MISS_MAX    = 8,
	parameter int HOLD_FRAMES = 5
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic bit_tick,
	input  wire logic bit_in,
	input  wire logic frame_start,
	output var  logic detected
);

	logic [PERIOD-1:0] hist_reg,  hist_next;
	logic [7:0]        ones_reg,  ones_next;
	logic [7:0]        miss_reg,  miss_next;
	logic [2:0]        good_reg,  good_next;
	logic              det_reg,   det_next;
	logic              frame_ok;

	// ************************************************************
	// per-frame scoring
	// ************************************************************
	// a bit error costs two mismatches, so the miss budget absorbs
	// the framing bit slip of unframed codes plus a 3e-3 error rate
	always_comb begin
		hist_next = hist_reg;
		ones_next = ones_reg;
		miss_next = miss_reg;
		good_next = good_reg;
		det_next  = det_reg;
		frame_ok  = (miss_reg <= 8'(MISS_MAX)) && (ones_reg >= 8'(ONES_MIN))
			&& (ones_reg <= 8'(ONES_MAX));
		if (frame_start) begin
			good_next = frame_ok ? ((good_reg == 3'h7) ? good_reg : good_reg + 3'h1) : 3'h0;
			det_next  = frame_ok && (good_reg >= 3'(HOLD_FRAMES - 1)); // [RL7] [RL8] [RL9]
			ones_next = 8'h00;
			miss_next = 8'h00;
		end else if (bit_tick) begin
			hist_next = {hist_reg[PERIOD-2:0], bit_in};
			ones_next = ones_reg + 8'(bit_in);
			miss_next = miss_reg + 8'(bit_in != hist_reg[PERIOD-1]);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hist_reg <= '0;
			ones_reg <= 8'h00;
			miss_reg <= 8'h00;
			good_reg <= 3'h0;
			det_reg  <= 1'b0;
		end else begin
			hist_reg <= hist_next;
			ones_reg <= ones_next;
			miss_reg <= miss_next;
			good_reg <= good_next;
			det_reg  <= det_next;
		end
	end

	assign detected = det_reg;

	a_detect_after_five: assert property (@(posedge clk) disable iff (sys_rst) // [RL7] [RL8]
		$rose(det_reg) |-> $past(good_reg) >= 3'(HOLD_FRAMES - 1))
		else $error("loop code flagged before enough good frames");

	a_detect_drops_bad: assert property (@(posedge clk) disable iff (sys_rst) // [RL9]
		frame_start && !frame_ok |=> !det_reg)
		else $error("loop code flag kept after a failing frame");

endmodule // t1lb_code_detect

`default_nettype wire

// ### verification/t1lb_framer_model.sv
// framer side model: sf framed t1 line with optional loop code payload
`include "t1lb_cfg.svh"
`default_nettype none

module t1lb_framer_model (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] pat,
	input  wire logic       ft_err,
	input  wire logic [1:0] fs_err,
	output var  logic       line_bit_tick,
	output var  logic       rx_rail_a_n,
	output var  logic       rx_rail_b_n,
	output var  logic       extracted_8k_in
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [23:0] SFP = `T1LB_SF_PATTERN;
	int   bitn = 0;
	int   frm  = 0;
	int   ph   = 0;
	logic b;
	logic pol  = 1'b0;
	initial begin
		line_bit_tick = 1'b0;
		extracted_8k_in = 1'b0;
		rx_rail_a_n = 1'b1;
		rx_rail_b_n = 1'b1;
	end
	// ****************************************
	// line generator
	// ****************************************
	always @(negedge clk) begin
		if (line_bit_tick) begin
			line_bit_tick <= 1'b0;
			rx_rail_a_n <= 1'b1;
			rx_rail_b_n <= 1'b1;
			// 8k edge one cycle ahead of the framing bit
			extracted_8k_in <= (bitn == 0);
		end else if (!sys_rst) begin
			if (bitn == 0) begin
				// framing bit leads each 193-bit frame
				b = SFP[frm];
				b ^= (ft_err && frm inside {0, 2}) || (fs_err == 1 && frm == 1);
				b ^= (fs_err == 2 && frm == 11);
			end else if (pat == 0) begin
				b = 1'b0;
			end else begin
				b = (ph % (pat == 1 ? 5 : 3)) == (pat == 1 ? 4 : 2);
				ph++;
				// one flipped bit every other frame stays under 3 in 1000
				b ^= (frm[0] && bitn == 100);
			end
			line_bit_tick <= 1'b1;
			extracted_8k_in <= 1'b0;
			// ami on active-low dual rails
			rx_rail_a_n <= !(b && !pol);
			rx_rail_b_n <= !(b && pol);
			pol ^= b;
			bitn = (bitn + 1) % 193;
			if (bitn == 0) frm = (frm + 1) % 12;
		end
	end
endmodule // t1lb_framer_model

`default_nettype wire

// ### verification/t1lb_loopback_sync_test.sv
// self-checking bench of the t1 loopback and synchronisation block
`default_nettype none

module t1lb_loopback_sync_test import t1lb_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic sk; logic [2:0] per; logic d; logic s; logic sc;} t1lb_exp_type;
	logic clk, sys_rst, stbus_frame_pulse, stbus_bit_tick, tx_stream_in, rx_stream_in;
	logic control_stream_in, framer_status_in, line_bit_tick, rx_rail_a_n, rx_rail_b_n;
	logic extracted_8k_in, bom_present_in, serial_data_out, status_stream_out;
	logic framing_bits_select, slost, go, ft_err, tg;
	logic [1:0] pat, fs_err;
	logic [7:0] h;
	logic [3:0] frame_error_count, c0;
	logic [14:0] bom_word_in;
	t1lb_misc_status_type misc_status_word;
	t1lb_loop_mode_type mode, mcur;
	t1lb_exp_type q[$];
	int err_total = 0;
	int check_count = 0;
	int n, i;

	// wiring of system, framer receive and framer transmit streams
	t1lb_loopback_sync #(.FRAMES_PER_SEC(13'h0004)) i_t1lb_loopback_sync (.clk, .sys_rst,
		.stbus_frame_pulse, .stbus_bit_tick, .tx_stream_in, .rx_stream_in, .control_stream_in,
		.framer_status_in, .line_bit_tick, .rx_rail_a_n, .rx_rail_b_n, .extracted_8k_in,
		.esf_mode_in(1'b0), .bom_present_in, .bom_word_in, .serial_data_out, .status_stream_out,
		.misc_status_word, .frame_error_count);
	t1lb_framer_model i_t1lb_framer_model (.clk, .sys_rst, .pat, .ft_err, .fs_err,
		.line_bit_tick, .rx_rail_a_n, .rx_rail_b_n, .extracted_8k_in);

	task automatic end_of_test;
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [3:0] ex, logic [3:0] got);
		check_count++;
		if (got !== ex) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wait_st(int b, logic v, int lim);
		int k;
		for (k = 0; k < lim && misc_status_word[b] !== v; k++) @(negedge clk);
		check_count++;
		if (k == lim) begin
			err_total++;
			$display("BAD misc_status_word[%0d] expected %b seen %b", b, v, misc_status_word[b]);
			end_of_test();
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#450000;
		err_total++;
		end_of_test();
	end

	// ****************************************
	// stream driver and monitor
	// ****************************************
	initial begin
		logic [4:0] c;
		int bi;
		logic tx, rx, st, ct, sk;
		{stbus_frame_pulse, stbus_bit_tick, tx_stream_in, rx_stream_in} = 4'h0;
		{control_stream_in, framer_status_in} = 2'h0;
		mcur = T1LB_PASS;
		wait (go === 1'b1);
		forever for (int p = 0; p < 256; p++) begin
			@(negedge clk);
			c = p[7:3];
			bi = 7 - p[2:0];
			if (p == 0) begin
				// a frame carrying a mode change is not checked
				sk = (mode != mcur);
				mcur = mode;
			end
			{tx, rx, st, ct} = 4'($urandom);
			if (c == 5'h0f && bi < 2) ct = mcur[bi];
			if (c == 5'h0b && bi == 3) ct = framing_bits_select;
			if (c == 5'h0f && bi == 0) st = slost;
			stbus_bit_tick = 1'b1;
			stbus_frame_pulse = (p == 0);
			tx_stream_in = tx;
			rx_stream_in = rx;
			control_stream_in = ct;
			framer_status_in = st;
			q.push_back('{sk, (c[1:0] != 0 && mcur[1]) ? (mcur[0] ? 3'h3 : 3'h5) : 3'h0,
				(c[1:0] != 0 && mcur == T1LB_PAYLOAD) ? rx : tx, (c == 5'h07) ? 1'b0 : st,
				c != 5'h07 || bi > 4});
			@(negedge clk);
			stbus_bit_tick = 1'b0;
			stbus_frame_pulse = 1'b0;
		end
	end
	always @(posedge clk) if (stbus_bit_tick === 1'b1 && q.size() > 0) begin
		t1lb_exp_type e;
		@(negedge clk);
		e = q.pop_front();
		if (e.sk) n = 0;
		else if (e.per == 0) chk("serial_data_out", e.d, serial_data_out);
		else begin
			h = {h[6:0], serial_data_out};
			n++;
			if (n > 5) chk("loop_code", 1, $countones(e.per == 5 ? h[4:0] : h[2:0]) == 1);
		end
		if (!e.sk && e.sc) chk("status_stream_out", e.s, status_stream_out);
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{sys_rst, go, bom_present_in, framing_bits_select, ft_err, slost} = 6'h21;
		{bom_word_in, pat, fs_err} = '0;
		mode = T1LB_PASS;
		i = $urandom(65050);
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		go = 1'b1;
		for (int m = 0; m < 4; m++) begin
			mode = t1lb_loop_mode_type'(m);
			repeat (1536) @(negedge clk);
		end
		mode = T1LB_PASS;
		framing_bits_select = 1'b1;
		chk("frame_count_valid", 0, misc_status_word.frame_count_valid);
		slost = 1'b0;
		wait_st(2, 1, 16000);
		slost = 1'b1;
		wait_st(2, 0, 1200);
		slost = 1'b0;
		wait_st(2, 1, 12000);
		framing_bits_select = 1'b0;
		repeat (1024) @(negedge clk);
		fs_err = 2'h1;
		c0 = frame_error_count;
		repeat (9264) @(negedge clk);
		chk("frame_error_count", c0, frame_error_count);
		framing_bits_select = 1'b1;
		repeat (5700) @(negedge clk);
		chk("frame_error_count_moved", 1, frame_error_count !== c0);
		chk("frame_count_valid", 1, misc_status_word.frame_count_valid);
		fs_err = 2'h2;
		repeat (400) @(negedge clk);
		c0 = frame_error_count;
		repeat (9264) @(negedge clk);
		chk("frame_error_count", c0, frame_error_count);
		fs_err = 2'h0;
		ft_err = 1'b1;
		wait_st(2, 0, 9000);
		chk("frame_error_count_moved", 1, frame_error_count !== c0);
		c0 = frame_error_count;
		repeat (4000) @(negedge clk);
		chk("frame_error_count", c0, frame_error_count);
		ft_err = 1'b0;
		// software must see a flag persist before switching the framer loop
		pat = 2'h1;
		wait_st(3, 1, 6000);
		pat = 2'h2;
		wait_st(4, 1, 6000);
		chk("loop_enable_detected", 0, misc_status_word.loop_enable_detected);
		pat = 2'h0;
		for (int k = 0; k < 2; k++) begin
			tg = misc_status_word.two_second_toggle;
			for (i = 0; i < 3000 && misc_status_word.two_second_toggle === tg; i++) @(negedge clk);
		end
		chk("two_second_toggle_period", 1, i == 2048);
		bom_word_in = {8'hfe, 6'($urandom), 1'b0};
		for (int k = 0; k < 3; k++) begin
			bom_present_in = (k != 2);
			bom_word_in[0] = (k == 1);
			repeat (2) @(negedge clk);
			chk("bitmsg_valid", k == 0, misc_status_word.bitmsg_valid);
		end
		end_of_test();
	end
endmodule // t1lb_loopback_sync_test

`default_nettype wire
